// >>> common/irq_pkg.sv
package irq_pkg;

  // ==========================================================
  // Sizes and register map
  localparam int          NUM_SRC      = 16;
  localparam int          STACK_DEPTH  = 8;
  localparam logic [7:0]  ADDR_FLAGS   = 8'h00;
  localparam logic [7:0]  ADDR_ENABLES = 8'h04;
  localparam logic [7:0]  ADDR_PRIO_LO = 8'h08;
  localparam logic [7:0]  ADDR_PRIO_HI = 8'h0c;
  localparam logic [7:0]  ADDR_CTRL1   = 8'h10;
  localparam logic [7:0]  ADDR_CTRL2   = 8'h14;
  localparam logic [7:0]  ADDR_STATUS  = 8'h18;
  localparam logic [7:0]  ADDR_CORCTL  = 8'h1c;

  // ==========================================================
  // Field positions and reset values
  localparam int          PRIO_NIBBLE  = 4;
  localparam int          NEST_DIS_BIT = 15;
  localparam int          ALT_VEC_BIT  = 15;
  localparam int          NUM_EXT      = 5;
  localparam int          LEVEL_LSB    = 5;
  localparam int          HIGH_BIT_POS = 3;
  localparam logic [15:0] CTRL1_MASK   = 16'hfffe;
  localparam logic [15:0] CTRL2_MASK   = 16'h801f;
  localparam logic [15:0] CORCTL_MASK  = 16'h0000;
  localparam logic [2:0]  LEVEL_MAX    = 3'h7;
  localparam logic [2:0]  LEVEL_RESET  = 3'h0;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    SEQ_IDLE, ENT_1, ENT_2, ENT_X, ENT_3, ENT_4,
    RET_POP1, RET_POP2, RET_FETCH, RET_RESUME
  } seq_state_t;

  // Instruction information from the core, same clock.
  typedef struct packed {
    logic return_from_interrupt_instr;
    logic movd_window;
    logic stall_two_cycle;
    logic stall_one_window;
    logic bit_test_window;
    logic trap_enter;
  } core_info_t;

  // Sequencing strobes to the core.
  typedef struct packed {
    logic       irq_take;
    logic       save_ctx;
    logic       vector_fetch;
    logic       isr_start;
    logic       pop_stack;
    logic       fetch_nop;
    logic       resume;
    logic       alt_vector;
    logic [3:0] vector_num;
  } core_ctl_t;

endpackage

// >>> design/irq_priority_return_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Return uses its first two cycles to pop counter and status low byte.
// RULE_02 - Third return cycle fetches at restored counter, executing as no-op.
// RULE_03 - Fourth return cycle resumes where the interrupt was taken.
// RULE_04 - Instruction in progress finishes; entry latency same for any length.
// RULE_05 - Four window or stall cases add one cycle of entry latency.
// RULE_06 - Each source owns a flag set by hardware, cleared by software.
// RULE_07 - Per-source enable bit gates whether its request may interrupt.
// RULE_08 - Each source takes one of eight priority levels from its field.
// RULE_09 - Low three level bits sit in status bits 7:5, software writable.
// RULE_10 - High level bit in core control is read-only to software.
// RULE_11 - Sources map to flag, enable and priority fields by vector number.
// RULE_12 - Low field is binary 0 to 7; level 7 blocks all user sources.
// RULE_13 - High bit above low field forms a 4-bit level, 8 to 15.
// RULE_14 - With nesting disabled the low level field ignores software writes.
// RULE_15 - Control two holds edge polarity and alternate vector selection.
// RULE_16 - Control one holds nesting disable plus trap control and status.
// RULE_17 - Reset clears the low level field and the high bit.
// RULE_18 - Present request only above current level; entry writes its level.
// RULE_19 - Nesting disabled forces level 7 until return.
// RULE_20 - Return restores counter, high bit and status low byte.
// RULE_21 - Equal priorities resolve to the lowest vector number.
module irq_priority_return_ctrl
  import irq_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_SRC-1:0] src_req,
  input  wire core_info_t         core_info,
  output core_ctl_t               core_ctl,
  output logic [3:0]              cpu_level
);

  // ==========================================================
  // Request synchronisers and edge detection
  logic [NUM_SRC-1:0] req_meta;
  logic [NUM_SRC-1:0] req_sync;
  logic [NUM_SRC-1:0] req_prev;
  logic [NUM_SRC-1:0] req_event;
  logic [NUM_SRC-1:0] edge_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_meta <= '0;
      req_sync <= '0;
      req_prev <= '0;
    end else begin
      req_meta <= src_req;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // ==========================================================
  // Register file
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] enables;
  logic [31:0]        prio_lo;
  logic [31:0]        prio_hi;
  logic [15:0]        ctrl_one;
  logic [15:0]        ctrl_two;
  logic [4:0]         status_rest;
  logic [2:0]         level_low;
  logic               level_high;
  seq_state_t         state;
  seq_state_t         next_state;

  wire nest_dis   = ctrl_one[NEST_DIS_BIT];
  wire alt_vector = ctrl_two[ALT_VEC_BIT];
  wire wr_access  = psel & penable & pwrite;
  wire wr_flags   = wr_access & (paddr == ADDR_FLAGS);
  wire wr_enables = wr_access & (paddr == ADDR_ENABLES);
  wire wr_prio_lo = wr_access & (paddr == ADDR_PRIO_LO);
  wire wr_prio_hi = wr_access & (paddr == ADDR_PRIO_HI);
  wire wr_ctrl1   = wr_access & (paddr == ADDR_CTRL1);
  wire wr_ctrl2   = wr_access & (paddr == ADDR_CTRL2);
  wire wr_status  = wr_access & (paddr == ADDR_STATUS);
  wire addr_ok    = (paddr[1:0] == 2'h0) & (paddr <= ADDR_CORCTL);

  // External requests may be turned to falling-edge sensitive.
  assign edge_fall = {{(NUM_SRC-NUM_EXT){1'b0}},
                      ctrl_two[NUM_EXT-1:0]}; // RULE_15
  assign req_event = (req_sync & ~req_prev & ~edge_fall)
                   | (~req_sync & req_prev & edge_fall);

  // Set wins over a clear in the same cycle, so no event is dropped.
  wire [NUM_SRC-1:0] next_flags =
    (flags & ~(wr_flags ? pwdata[NUM_SRC-1:0] : '0)) | req_event; // RULE_06

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags    <= '0;
      enables  <= '0;
      prio_lo  <= '0;
      prio_hi  <= '0;
      ctrl_one <= REG_RESET;
      ctrl_two <= REG_RESET;
    end else begin
      flags <= next_flags;
      if (wr_enables) enables  <= pwdata[NUM_SRC-1:0]; // RULE_07
      if (wr_prio_lo) prio_lo  <= pwdata; // RULE_08
      if (wr_prio_hi) prio_hi  <= pwdata;
      if (wr_ctrl1)   ctrl_one <= pwdata[15:0] & CTRL1_MASK; // RULE_16
      if (wr_ctrl2)   ctrl_two <= pwdata[15:0] & CTRL2_MASK; // RULE_15
    end
  end

  // ==========================================================
  // Arbitration
  logic [2:0] src_prio [NUM_SRC];
  logic [2:0] best_prio;
  logic [3:0] best_idx;
  logic       best_valid;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_prio
      if (g < 8) begin : g_lo
        assign src_prio[g] = prio_lo[g*PRIO_NIBBLE +: 3]; // RULE_11
      end else begin : g_hi
        assign src_prio[g] = prio_hi[(g-8)*PRIO_NIBBLE +: 3];
      end
    end
  endgenerate

  // Scanning from the top with >= leaves the lowest index on a tie.
  always_comb begin
    best_prio  = '0;
    best_idx   = '0;
    best_valid = 1'b0;
    for (int i = NUM_SRC-1; i >= 0; i--) begin
      if (flags[i] && enables[i] && src_prio[i] != 3'h0 &&
          (!best_valid || src_prio[i] >= best_prio)) begin // RULE_21
        best_prio  = src_prio[i];
        best_idx   = 4'(i);
        best_valid = 1'b1;
      end
    end
  end

  // The high bit lifts the level above every user priority.
  assign cpu_level = {level_high, level_low}; // RULE_13
  wire present = best_valid &&
                 ({1'b0, best_prio} > cpu_level); // RULE_18 RULE_12

  // ==========================================================
  // Entry and return sequencer
  logic [3:0] taken_idx;
  logic [2:0] taken_prio;
  logic       extra_cycle;
  logic [3:0] saved_level [STACK_DEPTH];
  logic [3:0] stack_ptr;

  wire slow_instr = core_info.movd_window | core_info.stall_two_cycle
                  | core_info.stall_one_window
                  | core_info.bit_test_window; // RULE_05
  wire start_ret  = (state == SEQ_IDLE) & core_info.return_from_interrupt_instr;
  wire start_ent  = (state == SEQ_IDLE) & ~core_info.return_from_interrupt_instr & present;
  wire do_push    = start_ent | core_info.trap_enter;
  wire [3:0] top_level = saved_level[3'(stack_ptr - 4'h1)];

  // Entry always spends its first two cycles letting the current
  // instruction drain, so one- and two-cycle instructions match.
  always_comb begin
    next_state = state;
    case (state)
      SEQ_IDLE:   if (start_ret) next_state = RET_POP1; // RULE_01
                  else if (start_ent) next_state = ENT_1; // RULE_04
      ENT_1:      next_state = ENT_2;
      ENT_2:      next_state = extra_cycle ? ENT_X : ENT_3; // RULE_05
      ENT_X:      next_state = ENT_3;
      ENT_3:      next_state = ENT_4;
      ENT_4:      next_state = SEQ_IDLE;
      RET_POP1:   next_state = RET_POP2; // RULE_01
      RET_POP2:   next_state = RET_FETCH; // RULE_02
      RET_FETCH:  next_state = RET_RESUME; // RULE_03
      RET_RESUME: next_state = SEQ_IDLE;
      default:    next_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= SEQ_IDLE;
      taken_idx   <= '0;
      taken_prio  <= '0;
      extra_cycle <= 1'b0;
    end else begin
      state <= next_state;
      if (start_ent) begin
        taken_idx   <= best_idx;
        taken_prio  <= best_prio;
        extra_cycle <= slow_instr;
      end
    end
  end

  // A small level stack stands in for the words the core pushes, so
  // that the return can reinstate the level; deeper nesting wraps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_ptr <= '0;
    end else if (do_push) begin
      stack_ptr <= stack_ptr + 4'h1;
    end else if (state == RET_POP2 && stack_ptr != 4'h0) begin
      stack_ptr <= stack_ptr - 4'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (do_push) saved_level[3'(stack_ptr)] <= cpu_level;
  end

  // ==========================================================
  // Priority level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_low   <= LEVEL_RESET; // RULE_17
      level_high  <= 1'b0;
      status_rest <= '0;
    end else begin
      if (core_info.trap_enter) begin
        level_high <= 1'b1;
      end else if (state == RET_POP2) begin
        level_high <= top_level[3]; // RULE_20
      end
      if (state == RET_POP2) begin
        level_low <= top_level[2:0]; // RULE_20
      end else if (state == ENT_4) begin
        level_low <= nest_dis ? LEVEL_MAX : taken_prio; // RULE_18 RULE_19
      end else if (wr_status && !nest_dis) begin
        level_low <= pwdata[LEVEL_LSB +: 3]; // RULE_09 RULE_14
      end
      if (wr_status) status_rest <= pwdata[4:0];
    end
  end

  // ==========================================================
  // Core strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ctl <= '0;
    end else begin
      core_ctl.irq_take     <= (next_state == ENT_1);
      core_ctl.save_ctx     <= (next_state == ENT_2);
      core_ctl.vector_fetch <= (next_state == ENT_3);
      core_ctl.isr_start    <= (next_state == ENT_4);
      core_ctl.pop_stack    <= (next_state == RET_POP1) |
                               (next_state == RET_POP2); // RULE_01
      core_ctl.fetch_nop    <= (next_state == RET_FETCH); // RULE_02
      core_ctl.resume       <= (next_state == RET_RESUME); // RULE_03
      core_ctl.alt_vector   <= alt_vector;
      core_ctl.vector_num   <= start_ent ? best_idx : taken_idx;
    end
  end

  // ==========================================================
  // Read path
  logic [31:0] rd_mux;
  wire         rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    case (paddr)
      ADDR_FLAGS:   rd_mux = {16'h0000, flags};
      ADDR_ENABLES: rd_mux = {16'h0000, enables};
      ADDR_PRIO_LO: rd_mux = prio_lo;
      ADDR_PRIO_HI: rd_mux = prio_hi;
      ADDR_CTRL1:   rd_mux = {16'h0000, ctrl_one};
      ADDR_CTRL2:   rd_mux = {16'h0000, ctrl_two};
      ADDR_STATUS:  rd_mux = {24'h000000, level_low, status_rest};
      ADDR_CORCTL:  rd_mux = {28'h0000000, level_high, 3'h0}; // RULE_10
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // Zero wait states keeps the bus simple; a bad address only errors.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Read data is caught in the setup cycle, so it stands from a
  // flip-flop through the whole access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ==========================================================
  // Checks
  property p_ret_seq;
    @(posedge pclk) disable iff (!presetn)
    start_ret |=> (state == RET_POP1) ##1 (state == RET_POP2)
      ##1 (state == RET_FETCH) ##1 (state == RET_RESUME);
  endproperty
  a_ret_seq: assert property (p_ret_seq) // RULE_01
    else $error("Return sequence out of order.");

  property p_ret_strobes;
    @(posedge pclk) disable iff (!presetn)
    $rose(core_ctl.pop_stack) |-> core_ctl.pop_stack [*2]
      ##1 core_ctl.fetch_nop ##1 core_ctl.resume;
  endproperty
  a_ret_strobes: assert property (p_ret_strobes) // RULE_02
    else $error("Return strobes not two pops, fetch, resume.");

  property p_entry_len;
    @(posedge pclk) disable iff (!presetn)
    start_ent && !slow_instr |-> ##4 (state == ENT_4);
  endproperty
  a_entry_len: assert property (p_entry_len) // RULE_04
    else $error("Entry did not take four cycles.");

  property p_entry_extra;
    @(posedge pclk) disable iff (!presetn)
    start_ent && slow_instr |-> ##5 (state == ENT_4);
  endproperty
  a_entry_extra: assert property (p_entry_extra) // RULE_05
    else $error("Slow instruction did not add one cycle.");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
    start_ent |-> enables[best_idx] && flags[best_idx]
      && {1'b0, best_prio} > cpu_level;
  endproperty
  a_gate: assert property (p_gate) // RULE_18
    else $error("Entry taken without enabled higher request.");

  property p_level_ro;
    @(posedge pclk) disable iff (!presetn)
    wr_status && nest_dis && state == SEQ_IDLE
      |=> $stable(level_low);
  endproperty
  a_level_ro: assert property (p_level_ro) // RULE_14
    else $error("Level changed by write while nesting disabled.");

  property p_nest_force;
    @(posedge pclk) disable iff (!presetn)
    state == ENT_4 && nest_dis |=> level_low == LEVEL_MAX;
  endproperty
  a_nest_force: assert property (p_nest_force) // RULE_19
    else $error("Nesting disabled entry did not force level 7.");

  property p_high_ro;
    @(posedge pclk) disable iff (!presetn)
    $rose(level_high) |-> $past(core_info.trap_enter);
  endproperty
  a_high_ro: assert property (p_high_ro) // RULE_10
    else $error("High level bit set without a trap.");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    |req_event |=> |flags;
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE_06
    else $error("Request edge did not set a flag.");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    !wr_flags |=> (($past(flags) & ~flags) == '0);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RULE_06
    else $error("Request flag dropped without a software clear.");

  property p_ent_order;
    @(posedge pclk) disable iff (!presetn)
    core_ctl.irq_take |=> core_ctl.save_ctx;
  endproperty
  a_ent_order: assert property (p_ent_order) // RULE_04
    else $error("Save cycle did not follow the take.");

  property p_level_write;
    @(posedge pclk) disable iff (!presetn)
    wr_status && !nest_dis && state == SEQ_IDLE
      |=> level_low == $past(pwdata[LEVEL_LSB +: 3]);
  endproperty
  a_level_write: assert property (p_level_write) // RULE_09
    else $error("Level write did not land in the low field.");

endmodule

// >>> test/core_model.sv
`timescale 1ns/1ps
module core_model
  import irq_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire core_ctl_t  core_ctl,
  input  wire logic       ret_cmd,
  input  wire logic       trap_cmd,
  input  wire logic [3:0] slow_sel,
  output core_info_t      core_info
);
  // ==========
  // Handler depth: a return is only issued from inside a handler.
  logic [3:0] depth;
  wire        can_ret = (depth != 4'h0);
  wire [3:0]  up = 4'(core_ctl.isr_start | trap_cmd);
  wire [3:0]  dn = 4'(core_ctl.resume);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth     <= 4'h0;
      core_info <= '0;
    end else begin
      depth                <= depth + up - dn;
      core_info.return_from_interrupt_instr     <= ret_cmd & can_ret;
      core_info.trap_enter <= trap_cmd;
      core_info.movd_window      <= slow_sel[0];
      core_info.stall_two_cycle  <= slow_sel[1];
      core_info.stall_one_window <= slow_sel[2];
      core_info.bit_test_window  <= slow_sel[3];
    end
  end
endmodule

// >>> test/irq_priority_return_ctrl_tb.sv
`timescale 1ns/1ps
module irq_priority_return_ctrl_tb;
  import irq_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [NUM_SRC-1:0] src_req = '0;
  core_info_t         core_info;
  core_ctl_t          core_ctl;
  logic [3:0]         cpu_level;
  logic               ret_cmd = 1'b0;
  logic               trap_cmd = 1'b0;
  logic [3:0]         slow_sel = 4'h0;
  logic [31:0]        rd;
  logic               err;
  int                 bad_count = 0;
  int                 check_count = 0;
  wire [2:0] ret_bits = {core_ctl.pop_stack, core_ctl.fetch_nop,
                         core_ctl.resume};

  always #20 pclk = ~pclk;

  irq_priority_return_ctrl irq_priority_return_ctrl_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .core_info(core_info),
    .core_ctl(core_ctl), .cpu_level(cpu_level));

  core_model core_model_i (.pclk(pclk), .presetn(presetn),
    .core_ctl(core_ctl), .ret_cmd(ret_cmd), .trap_cmd(trap_cmd),
    .slow_sel(slow_sel), .core_info(core_info));

  // ==========
  // Reporting.
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task timeout;
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    test_done();
  endtask

  // ==========
  // Bus and sequence helpers.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_take(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++) begin
      @(posedge pclk);
      seen = (core_ctl.irq_take === 1'b1);
    end
  endtask

  // Takes one entry, checks its timing and level, then clears the flag.
  task ent(input int s, input int lat, input logic [3:0] lvl);
    int   n;
    logic ok;
    src_req[s] <= 1'b1;
    wait_take(20, ok);
    if (!ok) timeout();
    check(32'(core_ctl.vector_num), s);
    n = 0;
    while (core_ctl.isr_start !== 1'b1 && n < 8) begin
      @(posedge pclk);
      n++;
      if (n == 1) check(32'(core_ctl.save_ctx), 32'h1);
      if (n == lat - 1) check(32'(core_ctl.vector_fetch), 32'h1);
    end
    check(n, lat);
    @(posedge pclk);
    check(32'(cpu_level), 32'(lvl));
    src_req[s] <= 1'b0;
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd[s], 32'h1);
    apb(1'b1, ADDR_FLAGS, 32'h1 << s);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd[s], 32'h0);
  endtask

  task ret(input logic [3:0] lvl);
    logic ok;
    ret_cmd <= 1'b1;
    @(posedge pclk);
    ret_cmd <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 10 && !ok; i++) begin
      @(posedge pclk);
      ok = (core_ctl.pop_stack === 1'b1);
    end
    if (!ok) timeout();
    @(posedge pclk);
    check(ret_bits, 32'h4);
    @(posedge pclk);
    check(ret_bits, 32'h2);
    @(posedge pclk);
    check(ret_bits, 32'h1);
    check(32'(cpu_level), 32'(lvl));
  endtask

  // ==========
  // Main sequence.
  initial begin
    logic ok;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, ADDR_CORCTL, 32'hffff);
    apb(1'b0, ADDR_CORCTL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, ADDR_CTRL2, 32'hffff);
    apb(1'b0, ADDR_CTRL2, 32'h0);
    check(rd, 32'h801f);
    check(core_ctl.alt_vector, 32'h1);
    apb(1'b1, ADDR_CTRL2, 32'h0);
    apb(1'b1, ADDR_CTRL1, 32'hffff);
    apb(1'b0, ADDR_CTRL1, 32'h0);
    check(rd, 32'hfffe);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    apb(1'b1, ADDR_ENABLES, 32'hffff);
    apb(1'b1, ADDR_PRIO_LO, 32'h6000_0003);
    apb(1'b1, ADDR_PRIO_HI, 32'h0000_0022);
    ent(0, 3, 4'h3);
    ret(4'h0);
    for (int k = 0; k < 4; k++) begin
      slow_sel <= 4'h1 << k;
      ent(0, 4, 4'h3);
      slow_sel <= 4'h0;
      ret(4'h0);
    end
    ent(0, 3, 4'h3);
    ent(7, 3, 4'h6);
    ret(4'h3);
    ret(4'h0);
    src_req[9] <= 1'b1;
    ent(8, 3, 4'h2);
    ret(4'h0);
    ent(9, 3, 4'h2);
    ret(4'h0);
    apb(1'b1, ADDR_STATUS, 32'ha0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[7:5], 32'h5);
    check(cpu_level, 32'h5);
    src_req[0] <= 1'b1;
    wait_take(15, ok);
    check(ok, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'he0);
    src_req[7] <= 1'b1;
    wait_take(15, ok);
    check(ok, 32'h0);
    src_req <= '0;
    apb(1'b1, ADDR_FLAGS, 32'hffff);
    apb(1'b1, ADDR_CTRL2, 32'h1);
    src_req[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd[0], 32'h0);
    src_req[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    check(rd[0], 32'h1);
    apb(1'b1, ADDR_FLAGS, 32'h1);
    apb(1'b1, ADDR_CTRL2, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_CTRL1, 32'h8000);
    apb(1'b1, ADDR_STATUS, 32'h40);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd[7:5], 32'h0);
    ent(0, 3, 4'h7);
    ret(4'h0);
    apb(1'b1, ADDR_CTRL1, 32'h0);
    trap_cmd <= 1'b1;
    @(posedge pclk);
    trap_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    check(cpu_level, 32'h8);
    apb(1'b0, ADDR_CORCTL, 32'h0);
    check(rd, 32'h8);
    src_req[7] <= 1'b1;
    wait_take(15, ok);
    check(ok, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CORCTL, 32'h0);
    check(rd, 32'h0);
    check(32'(cpu_level), 32'h0);
    test_done();
  end
endmodule
